// File: hw/flash_guard_defs.vh
`ifndef FLASH_GUARD_DEFS_VH
`define FLASH_GUARD_DEFS_VH

// ****************************************************************
// command addresses and codes
// ****************************************************************
`define UNLOCK_ADDR_1      20'h05555
`define UNLOCK_ADDR_2      20'h02AAA
`define GEN_QUERY_ADDR     20'h00055
`define UNLOCK_CODE_1      8'hAA
`define UNLOCK_CODE_2      8'h55
`define CODE_PROGRAM       8'hA0
`define CODE_ERASE_SETUP   8'h80
`define CODE_CHIP_ERASE    8'h10
`define CODE_SECTOR_ERASE  8'h30
`define CODE_BLOCK_ERASE   8'h50
`define CODE_SEC_PROGRAM   8'hA5
`define CODE_SEC_LOCK      8'h85
`define CODE_ID_ENTRY      8'h90
`define CODE_QUERY_ENTRY   8'h98
`define CODE_SECID_ENTRY   8'h88
`define CODE_EXIT          8'hF0
`define UPPER_BYTE_FILL    8'h00

// ****************************************************************
// identification and security space addresses
// ****************************************************************
`define ID_MAKER_ADDR      20'h00000
`define ID_PART_ADDR       20'h00001
`define SEC_FACTORY_BASE   20'h00000
`define SEC_USER_BASE      20'h00008
`define SEC_LOCK_DATA      16'h0000

// ****************************************************************
// protected boot block (32 KWord)
// ****************************************************************
`define BOOT_BOTTOM_LO     20'h00000
`define BOOT_BOTTOM_HI     20'h07FFF
`define BOOT_TOP_LO        20'hF8000
`define BOOT_TOP_HI        20'hFFFFF

// ****************************************************************
// bus timing
// ****************************************************************
`define CLK_PERIOD_NS      40
`define WE_PULSE_NS        80
`define WE_PULSE_CYC       ((`WE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYCLE_NS      120
`define READ_CYCLE_CYC     ((`READ_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_PULSE_NS     1000
`define RESET_PULSE_CYC    ((`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_READ_NS      1000
`define RESET_READ_CYC     ((`RESET_READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W              8

`endif

// File: hw/cmd_rom.v
`timescale 1ns/10ps
// ****************************************************************
// command step table: registered address/data for step of a command
// ****************************************************************
`include "flash_guard_defs.vh"
module cmd_rom (
  // clock
  input  wire        sys_clk_i,
  // lookup
  input  wire [3:0]  op_i,
  input  wire [2:0]  step_i,
  output reg  [19:0] addr_o,
  output reg  [7:0]  code_o
);
  // op codes: 0 program 1 chip 2 sector 3 block 4 secid 5 id 6 query
  //           7 gen query 8 exit 9 short exit 10 sec program 11 sec lock
  reg [19:0] a_next;
  reg [7:0]  c_next;

  always @* begin
    a_next = `UNLOCK_ADDR_1;
    c_next = `UNLOCK_CODE_1;
    case (step_i)
      3'h0: begin
        if (op_i == 4'h7) begin
          a_next = `GEN_QUERY_ADDR;
          c_next = `CODE_QUERY_ENTRY;
        end else if (op_i == 4'h9) begin
          a_next = 20'h00000;
          c_next = `CODE_EXIT;
        end
      end
      3'h1: begin
        a_next = `UNLOCK_ADDR_2;
        c_next = `UNLOCK_CODE_2;
      end
      3'h2: begin
        case (op_i)
          4'h0:    c_next = `CODE_PROGRAM;
          4'h1,
          4'h2,
          4'h3:    c_next = `CODE_ERASE_SETUP;
          4'h4:    c_next = `CODE_SECID_ENTRY;
          4'h5:    c_next = `CODE_ID_ENTRY;
          4'h6:    c_next = `CODE_QUERY_ENTRY;
          4'hA:    c_next = `CODE_SEC_PROGRAM;
          4'hB:    c_next = `CODE_SEC_LOCK;
          default: c_next = `CODE_EXIT;
        endcase
      end
      3'h4: begin
        a_next = `UNLOCK_ADDR_2;
        c_next = `UNLOCK_CODE_2;
      end
      3'h5: begin
        case (op_i)
          4'h2:    c_next = `CODE_SECTOR_ERASE;
          4'h3:    c_next = `CODE_BLOCK_ERASE;
          default: c_next = `CODE_CHIP_ERASE;
        endcase
      end
      default: begin
        a_next = `UNLOCK_ADDR_1;
        c_next = `UNLOCK_CODE_1;
      end
    endcase
  end

  always @(posedge sys_clk_i) begin
    addr_o <= a_next;
    code_o <= c_next;
  end
endmodule

// File: hw/flash_host_ctrl.v
`timescale 1ns/10ps
`include "flash_guard_defs.vh"
module flash_host_ctrl (
  // clock and reset
  input  wire        sys_clk_i,
  input  wire        reset_n_i,
  // user request
  input  wire        req_i,
  input  wire [3:0]  op_i,
  input  wire        rd_i,
  input  wire [19:0] addr_i,
  input  wire [15:0] wdata_i,
  input  wire        top_boot_i,
  input  wire        protect_i,
  input  wire        flash_reset_req_i,
  input  wire        supply_ok_i,
  output reg         busy_o,
  output reg         done_o,
  output reg         refused_o,
  output reg  [15:0] rdata_o,
  output reg  [2:0]  mode_o,
  output reg         reissue_o,
  // flash pins
  output reg  [19:0] fl_addr_o,
  input  wire [15:0] fl_dq_i,
  output reg  [15:0] fl_dq_o,
  output reg         fl_dq_oe_o,
  output reg         fl_ce_n_o,
  output reg         fl_oe_n_o,
  output reg         fl_we_n_o,
  output reg         fl_wp_n_o,
  output reg         fl_wp_n_oe_o,
  output reg         fl_rst_n_o
);
  // ****************************************************************
  // states and modes
  // ****************************************************************
  localparam ST_IDLE  = 3'h0;
  localparam ST_SETUP = 3'h1;
  localparam ST_WE    = 3'h2;
  localparam ST_REC   = 3'h3;
  localparam ST_READ  = 3'h4;
  localparam ST_POLL  = 3'h5;
  localparam ST_RST   = 3'h6;
  localparam ST_RWAIT = 3'h7;
  localparam M_ARRAY  = 3'h0;
  localparam M_ID     = 3'h1;
  localparam M_QUERY  = 3'h2;
  localparam M_SECID  = 3'h3;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg [15:0] dq_s1_reg;
  reg [15:0] dq_s2_reg;
  reg        sup_s1_reg;
  reg        sup_s2_reg;
  always @(posedge sys_clk_i) begin
    dq_s1_reg  <= fl_dq_i;
    dq_s2_reg  <= dq_s1_reg;
    sup_s1_reg <= supply_ok_i;
    sup_s2_reg <= sup_s1_reg;
  end

  // ****************************************************************
  // command table
  // ****************************************************************
  reg  [3:0]  op_reg;
  reg  [2:0]  step_reg;
  wire [19:0] rom_addr;
  wire [7:0]  rom_code;
  wire [3:0]  rom_op;
  wire [2:0]  rom_step;
  cmd_rom u_rom (
    .sys_clk_i (sys_clk_i),
    .op_i      (rom_op),
    .step_i    (rom_step),
    .addr_o    (rom_addr),
    .code_o    (rom_code)
  );

  reg [2:0]          state_reg;
  reg [`CNT_W-1:0]   cnt_reg;
  reg [19:0]         taddr_reg;
  reg [15:0]         tdata_reg;
  reg                lock_reg;
  reg                act_reg;
  reg                tog_reg;
  reg                tog_ok_reg;

  // total writes of each command; last write carries the user address for ops 0, 2, 3, 10 and 11
  wire [2:0] n_writes  = (op_reg == 4'h0 || op_reg >= 4'hA) ? 3'h4 :
                         (op_reg <= 4'h3) ? 3'h6 :
                         (op_reg == 4'h7 || op_reg == 4'h9) ? 3'h1 :
                         3'h3;
  wire       last_user = (op_reg == 4'h0) || (op_reg == 4'h2) || (op_reg == 4'h3) ||
                         (op_reg >= 4'hA);

  wire in_boot = top_boot_i ? (addr_i >= `BOOT_TOP_LO) : (addr_i <= `BOOT_BOTTOM_HI);
  // refuse writes into protected block, factory security half, locked user space
  wire bad_req = (protect_i && in_boot && (op_i == 4'h0 || op_i == 4'h2 ||
                  op_i == 4'h3)) ||
                 (protect_i && op_i == 4'h1) ||
                 (lock_reg && op_i == 4'hA) ||
                 (op_i == 4'hA && addr_i < `SEC_USER_BASE) ||
                 (op_i >= 4'hC) || !sup_s2_reg;
  wire is_last   = (step_reg == n_writes - 3'h1);
  wire long_op   = (op_reg <= 4'h3) || (op_reg == 4'hA);
  // only program words carry user data; an erase ends with its command code
  wire        user_data = is_last && (op_reg == 4'h0 || op_reg == 4'hA);
  wire [19:0] wr_addr = (is_last && last_user) ? taddr_reg : rom_addr;
  wire [15:0] wr_data = user_data ? tdata_reg :
                        (is_last && op_reg == 4'hB) ? `SEC_LOCK_DATA :
                        {`UPPER_BYTE_FILL, rom_code};
  // table is registered: feed it the step that the next cycle uses
  assign rom_op   = (state_reg == ST_IDLE) ? op_i : op_reg;
  assign rom_step = (state_reg == ST_IDLE) ? 3'h0 :
                    (state_reg == ST_REC && !is_last) ? step_reg + 3'h1 : step_reg;

  always @(posedge sys_clk_i) begin
    done_o    <= 1'b0;
    refused_o <= 1'b0;
    if (!reset_n_i) begin
      state_reg    <= ST_RST;
      cnt_reg      <= {`CNT_W{1'b0}};
      op_reg       <= 4'h0;
      step_reg     <= 3'h0;
      taddr_reg    <= 20'h00000;
      tdata_reg    <= 16'h0000;
      lock_reg     <= 1'b0;
      act_reg      <= 1'b0;
      tog_reg      <= 1'b0;
      tog_ok_reg   <= 1'b0;
      busy_o       <= 1'b1;
      rdata_o      <= 16'h0000;
      mode_o       <= M_ARRAY;
      reissue_o    <= 1'b0;
      fl_addr_o    <= 20'h00000;
      fl_dq_o      <= 16'h0000;
      fl_dq_oe_o   <= 1'b0;
      fl_ce_n_o    <= 1'b1;
      fl_oe_n_o    <= 1'b1;
      fl_we_n_o    <= 1'b1;
      fl_wp_n_o    <= 1'b0;
      fl_wp_n_oe_o <= 1'b0;
      fl_rst_n_o   <= 1'b0;
    end else begin
      fl_wp_n_oe_o <= protect_i;
      case (state_reg)
        ST_RST: begin
          if (cnt_reg == `RESET_PULSE_CYC - 1) begin
            cnt_reg    <= {`CNT_W{1'b0}};
            fl_rst_n_o <= 1'b1;
            reissue_o  <= act_reg;
            act_reg    <= 1'b0;
            mode_o     <= M_ARRAY;
            state_reg  <= ST_RWAIT;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_RWAIT: begin
          if (cnt_reg == `RESET_READ_CYC - 1) begin
            cnt_reg   <= {`CNT_W{1'b0}};
            busy_o    <= 1'b0;
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_IDLE: begin
          if (req_i && !flash_reset_req_i) begin
            op_reg    <= op_i;
            taddr_reg <= addr_i;
            tdata_reg <= wdata_i;
            step_reg  <= 3'h0;
            if (!rd_i && bad_req) begin
              refused_o <= 1'b1;
              done_o    <= 1'b1;
            end else begin
              busy_o    <= 1'b1;
              reissue_o <= 1'b0;
              state_reg <= rd_i ? ST_READ : ST_SETUP;
            end
          end
        end
        ST_SETUP: begin
          // table output is registered and valid here; address and data go out on the same edge as the write strobe
          fl_addr_o  <= wr_addr;
          fl_dq_o    <= wr_data;
          fl_dq_oe_o <= 1'b1;
          fl_oe_n_o  <= 1'b1;
          fl_ce_n_o  <= 1'b0;
          fl_we_n_o  <= 1'b0;
          cnt_reg    <= {`CNT_W{1'b0}};
          state_reg  <= ST_WE;
        end
        ST_WE: begin
          if (cnt_reg == `WE_PULSE_CYC - 1) begin
            fl_we_n_o <= 1'b1;
            cnt_reg   <= {`CNT_W{1'b0}};
            state_reg <= ST_REC;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_REC: begin
          // deselect only after the strobe has risen, so the word latches while selected
          fl_ce_n_o  <= 1'b1;
          fl_dq_oe_o <= 1'b0;
          if (!is_last) begin
            step_reg  <= step_reg + 3'h1;
            state_reg <= ST_SETUP;
          end else if (long_op) begin
            act_reg    <= 1'b1;
            tog_ok_reg <= 1'b0;
            state_reg  <= ST_POLL;
          end else if (cnt_reg == `READ_CYCLE_CYC - 1) begin
            case (op_reg)
              4'h4:       mode_o <= M_SECID;
              4'h5:       mode_o <= M_ID;
              4'h6, 4'h7: mode_o <= M_QUERY;
              4'hB:       lock_reg <= 1'b1;
              default:    mode_o <= M_ARRAY;
            endcase
            cnt_reg   <= {`CNT_W{1'b0}};
            busy_o    <= 1'b0;
            done_o    <= 1'b1;
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_POLL: begin
          // toggle reads: finish when bit 6 repeats on two reads
          fl_addr_o <= taddr_reg;
          fl_ce_n_o <= 1'b0;
          fl_oe_n_o <= 1'b0;
          if (cnt_reg == `READ_CYCLE_CYC + 1) begin
            cnt_reg    <= {`CNT_W{1'b0}};
            fl_oe_n_o  <= 1'b1;
            fl_ce_n_o  <= 1'b1;
            tog_reg    <= dq_s2_reg[6];
            tog_ok_reg <= 1'b1;
            if (tog_ok_reg && tog_reg == dq_s2_reg[6] && !flash_reset_req_i) begin
              act_reg   <= 1'b0;
              busy_o    <= 1'b0;
              done_o    <= 1'b1;
              state_reg <= ST_IDLE;
            end
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_READ: begin
          fl_addr_o <= taddr_reg;
          fl_ce_n_o <= 1'b0;
          fl_oe_n_o <= 1'b0;
          fl_we_n_o <= 1'b1;
          if (cnt_reg == `READ_CYCLE_CYC + 1) begin
            cnt_reg   <= {`CNT_W{1'b0}};
            rdata_o   <= dq_s2_reg;
            fl_oe_n_o <= 1'b1;
            fl_ce_n_o <= 1'b1;
            busy_o    <= 1'b0;
            done_o    <= 1'b1;
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
      // flash reset is taken in idle or while an operation is being polled
      if (flash_reset_req_i && (state_reg == ST_IDLE || state_reg == ST_POLL)) begin
        busy_o     <= 1'b1;
        fl_rst_n_o <= 1'b0;
        fl_ce_n_o  <= 1'b1;
        fl_oe_n_o  <= 1'b1;
        cnt_reg    <= {`CNT_W{1'b0}};
        state_reg  <= ST_RST;
      end
    end
  end
endmodule

// File: tb/flash_dev_model.sv
`timescale 1ns/10ps
module flash_dev_model #(
  parameter [15:0] MAKER_CODE = 16'h00C3, // arbitrary value
  parameter [15:0] PART_CODE  = 16'h5A17, // arbitrary value
  parameter        TOP_BOOT   = 0
) (
  // flash pins
  input  wire  [19:0] fl_addr_i,
  input  wire  [15:0] fl_dq_i,
  input  wire         fl_ce_n_i,
  input  wire         fl_oe_n_i,
  input  wire         fl_we_n_i,
  input  wire         fl_wp_n_i,
  input  wire         fl_rst_n_i,
  output logic [15:0] fl_dq_o
);
  bit   [15:0] mem [0:1048575];
  logic [15:0] sec [0:15];
  int          step = 0;
  int          mode = 0;
  int          busy = 0;
  logic        locked = 0;
  logic        tgl = 0;
  wire  [7:0]  cd = fl_dq_i[7:0];
  wire  [19:0] a = fl_addr_i;
  wire         prot = !fl_wp_n_i && (TOP_BOOT ? a >= 20'hF8000 : a <= 20'h07FFF);
  wire         u1 = cd == 8'hAA && a[14:0] == 15'h5555;
  wire         u2 = cd == 8'h55 && a[14:0] == 15'h2AAA;

  function automatic [15:0] rd_val(input [19:0] ad, input int md, input int bz, input t);
    if (bz > 0) rd_val = {9'h000, t, 6'h00};
    else if (md == 1) rd_val = ad[0] ? PART_CODE : MAKER_CODE;
    else if (md == 2) rd_val = {12'h005, ad[3:0]};
    else if (md == 3) rd_val = sec[ad[3:0]];
    else rd_val = mem[ad];
  endfunction

  task automatic wipe(input int lo, input int n);
    for (int k = lo; k < lo + n; k++) mem[k] = 16'hFFFF;
  endtask

  initial begin
    for (int i = 0; i < 1048576; i++) mem[i] = 16'hFFFF;
    for (int i = 0; i < 16; i++) sec[i] = (i < 8) ? 16'h1230 + i : 16'hFFFF;
  end

  // released bus shows the inverse, never stale data
  assign fl_dq_o = (!fl_ce_n_i && !fl_oe_n_i && fl_rst_n_i) ? rd_val(a, mode, busy, tgl)
                                                           : ~rd_val(a, mode, busy, tgl);

  always @(posedge fl_oe_n_i) begin
    tgl = !tgl;
    if (busy > 0) busy = busy - 1;
  end

  always @(negedge fl_rst_n_i) begin
    step = 0;
    mode = 0;
    busy = 0;
  end

  always @(posedge fl_we_n_i) begin
    if (fl_rst_n_i && !fl_ce_n_i && fl_oe_n_i && busy == 0) begin
      case (step)
        0: begin
          if (u1) step = 1;
          else if (cd == 8'hF0) mode = 0;
          else if (cd == 8'h98 && a[14:0] == 15'h0055) mode = 2;
        end
        1: step = u2 ? 2 : 0;
        2: begin
          step = 0;
          if (a[14:0] == 15'h5555) begin
            case (cd)
              8'hA0: step = 3;
              8'hA5: step = 4;
              8'h85: step = 5;
              8'h80: step = 6;
              8'h90: mode = 1;
              8'h98: mode = 2;
              8'h88: mode = 3;
              8'hF0: mode = 0;
              default: step = 0;
            endcase
          end
        end
        3: begin
          step = 0;
          busy = 3;
          if (!prot) mem[a] = mem[a] & fl_dq_i;
        end
        4: begin
          step = 0;
          busy = 3;
          if (!locked && a[3]) sec[a[3:0]] = sec[a[3:0]] & fl_dq_i;
        end
        5: begin
          step = 0;
          locked = 1;
        end
        6: step = u1 ? 7 : 0;
        7: step = u2 ? 8 : 0;
        default: begin
          step = 0;
          busy = 3;
          // security space is never touched by erase
          if (cd == 8'h10 && fl_wp_n_i) wipe(0, 1048576);
          else if (cd == 8'h30 && !prot) wipe({a[19:11], 11'h000}, 2048);
          else if (cd == 8'h50 && !prot) wipe({a[19:15], 15'h0000}, 32768);
        end
      endcase
    end
  end
endmodule

// File: tb/flash_host_ctrl_chk.sv
`timescale 1ns/10ps
module flash_host_ctrl_chk (
  // clock and reset
  input wire        sys_clk_i,
  input wire        reset_n_i,
  // watched ports
  input wire        protect_i,
  input wire        busy_o,
  input wire        done_o,
  input wire        refused_o,
  input wire [15:0] fl_dq_o,
  input wire        fl_dq_oe_o,
  input wire        fl_ce_n_o,
  input wire        fl_oe_n_o,
  input wire        fl_we_n_o,
  input wire        fl_wp_n_o,
  input wire        fl_wp_n_oe_o,
  input wire        fl_rst_n_o
);
  localparam int RST_MIN = 25;
  int low_cnt = 0;
  int high_cnt = 0;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  always @(posedge sys_clk_i) begin
    low_cnt  <= fl_rst_n_o ? 0 : low_cnt + 1;
    high_cnt <= !fl_rst_n_o ? 0 : (high_cnt < 99 ? high_cnt + 1 : high_cnt);
  end

  sequence we_start;
    $fell(fl_we_n_o);
  endsequence
  sequence we_held;
    !fl_we_n_o ##1 !fl_we_n_o;
  endsequence

  AST_WE_MIN_WIDTH: assert property (we_start |-> we_held)
    else $error("write strobe pulse too short");
  AST_WRITE_OE_HIGH: assert property (!fl_we_n_o |-> fl_oe_n_o && !fl_ce_n_o && fl_dq_oe_o)
    else $error("write strobe low without write qualifiers");
  AST_READ_NO_DRIVE: assert property (!fl_oe_n_o |-> fl_we_n_o && !fl_dq_oe_o)
    else $error("data driven or strobed during read");
  AST_UPPER_BYTE: assert property (!fl_we_n_o && fl_dq_o[7:0] == 8'hAA |-> fl_dq_o[15:8] == 8'h00)
    else $error("upper byte not defined in unlock write");
  AST_WP_DRIVE: assert property (protect_i |=> fl_wp_n_oe_o && !fl_wp_n_o)
    else $error("protect pin not driven low");
  AST_WP_RELEASE: assert property (!protect_i |=> !fl_wp_n_oe_o)
    else $error("protect pin not released");
  AST_RST_PULSE: assert property ($rose(fl_rst_n_o) |-> low_cnt >= RST_MIN)
    else $error("flash reset pulse too short");
  AST_RST_BUSY: assert property (!fl_rst_n_o |-> busy_o)
    else $error("idle while flash reset low");
  AST_RST_READ: assert property ($fell(fl_oe_n_o) |-> high_cnt >= RST_MIN)
    else $error("read too soon after flash reset");
  AST_REFUSE_QUIET: assert property (refused_o |-> done_o && fl_ce_n_o && fl_we_n_o)
    else $error("refused request touched the pins");
endmodule

bind flash_host_ctrl flash_host_ctrl_chk flash_host_ctrl_chk_inst (
  .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .protect_i(protect_i), .busy_o(busy_o),
  .done_o(done_o), .refused_o(refused_o), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o),
  .fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o),
  .fl_wp_n_o(fl_wp_n_o), .fl_wp_n_oe_o(fl_wp_n_oe_o), .fl_rst_n_o(fl_rst_n_o));

// File: tb/flash_write_guard_and_id_modes_tb.sv
`timescale 1ns/10ps
module flash_write_guard_and_id_modes_tb;
  logic        sys_clk_i = 0;
  logic        reset_n_i = 0;
  logic        req_i = 0;
  logic [3:0]  op_i = 0;
  logic        rd_i = 0;
  logic [19:0] addr_i = 0;
  logic [15:0] wdata_i = 0;
  logic        protect_i = 0;
  logic        fl_reset_req = 0;
  logic        supply_ok_i = 1;
  wire         busy_o, done_o, refused_o, reissue_o, fl_dq_oe_o, fl_ce_n_o, fl_oe_n_o;
  wire         fl_we_n_o, fl_wp_n_o, fl_wp_n_oe_o, fl_rst_n_o;
  wire  [15:0] rdata_o, fl_dq_o, dev_dq;
  wire  [2:0]  mode_o;
  wire  [19:0] fl_addr_o;
  wire  [15:0] dq_bus = fl_dq_oe_o ? fl_dq_o : dev_dq;
  wire         wp_n = fl_wp_n_oe_o ? fl_wp_n_o : 1'b1;
  logic        ref_seen;
  int          n_errors = 0;
  int          num_checks = 0;

  always #20 sys_clk_i = ~sys_clk_i;

  flash_host_ctrl flash_host_ctrl_inst (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .req_i(req_i), .op_i(op_i), .rd_i(rd_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .top_boot_i(1'b0), .protect_i(protect_i),
    .flash_reset_req_i(fl_reset_req), .supply_ok_i(supply_ok_i), .busy_o(busy_o),
    .done_o(done_o), .refused_o(refused_o), .rdata_o(rdata_o), .mode_o(mode_o),
    .reissue_o(reissue_o), .fl_addr_o(fl_addr_o), .fl_dq_i(dq_bus), .fl_dq_o(fl_dq_o),
    .fl_dq_oe_o(fl_dq_oe_o), .fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o),
    .fl_we_n_o(fl_we_n_o), .fl_wp_n_o(fl_wp_n_o), .fl_wp_n_oe_o(fl_wp_n_oe_o),
    .fl_rst_n_o(fl_rst_n_o));

  flash_dev_model flash_dev_model_inst (
    .fl_addr_i(fl_addr_o), .fl_dq_i(dq_bus), .fl_ce_n_i(fl_ce_n_o), .fl_oe_n_i(fl_oe_n_o),
    .fl_we_n_i(fl_we_n_o), .fl_wp_n_i(wp_n), .fl_rst_n_i(fl_rst_n_o), .fl_dq_o(dev_dq));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wait_idle;
    int i;
    for (i = 0; i < 3000 && busy_o !== 1'b0; i++) @(negedge sys_clk_i);
    if (i == 3000) begin
      n_errors++;
      give_verdict;
    end
  endtask

  task automatic run(input [3:0] op, input rd, input [19:0] a, input [15:0] d);
    int i;
    @(negedge sys_clk_i);
    op_i = op;
    rd_i = rd;
    addr_i = a;
    wdata_i = d;
    req_i = 1;
    @(negedge sys_clk_i);
    req_i = 0;
    for (i = 0; i < 3000 && done_o !== 1'b1; i++) @(negedge sys_clk_i);
    ref_seen = refused_o;
    if (i == 3000) begin
      n_errors++;
      give_verdict;
    end
  endtask

  task automatic rd_chk(input [19:0] a, input [15:0] exp);
    run(4'h0, 1'b1, a, 16'h0000);
    check(rdata_o, exp);
  endtask

  task automatic t_ident;
    run(4'h5, 1'b0, 20'h00000, 16'h0000);
    check({13'h0000, mode_o}, 16'h0001);
    rd_chk(20'h00000, 16'h00C3);
    rd_chk(20'h00001, 16'h5A17);
    run(4'h8, 1'b0, 20'h00000, 16'h0000);
    check({13'h0000, mode_o}, 16'h0000);
    rd_chk(20'h00001, 16'hFFFF);
    $display("test ident done");
  endtask

  task automatic t_query;
    run(4'h6, 1'b0, 20'h00000, 16'h0000);
    rd_chk(20'h00003, 16'h0053);
    rd_chk(20'h00007, 16'h0057);
    run(4'h9, 1'b0, 20'h00000, 16'h0000);
    rd_chk(20'h00003, 16'hFFFF);
    run(4'h7, 1'b0, 20'h00000, 16'h0000);
    check({13'h0000, mode_o}, 16'h0002);
    rd_chk(20'h00004, 16'h0054);
    run(4'h8, 1'b0, 20'h00000, 16'h0000);
    rd_chk(20'h00004, 16'hFFFF);
    $display("test query done");
  endtask

  task automatic t_protect;
    protect_i = 1;
    run(4'h0, 1'b0, 20'h00010, 16'h1234);
    check({15'h0000, ref_seen}, 16'h0001);
    rd_chk(20'h00010, 16'hFFFF);
    run(4'h0, 1'b0, 20'h08000, 16'h1234);
    check({15'h0000, ref_seen}, 16'h0000);
    rd_chk(20'h08000, 16'h1234);
    protect_i = 0;
    run(4'h0, 1'b0, 20'h00010, 16'h0F0F);
    rd_chk(20'h00010, 16'h0F0F);
    run(4'h2, 1'b0, 20'h08000, 16'h0000);
    rd_chk(20'h08000, 16'hFFFF);
    $display("test protect done");
  endtask

  task automatic t_sec;
    run(4'h4, 1'b0, 20'h00000, 16'h0000);
    check({13'h0000, mode_o}, 16'h0003);
    rd_chk(20'h00002, 16'h1232);
    rd_chk(20'h00009, 16'hFFFF);
    run(4'hA, 1'b0, 20'h00009, 16'h00C5);
    rd_chk(20'h00009, 16'h00C5);
    run(4'hA, 1'b0, 20'h00002, 16'h0000);
    check({15'h0000, ref_seen}, 16'h0001);
    rd_chk(20'h00002, 16'h1232);
    run(4'hB, 1'b0, 20'h00009, 16'h0000);
    run(4'hA, 1'b0, 20'h00009, 16'h0000);
    check({15'h0000, ref_seen}, 16'h0001);
    rd_chk(20'h00009, 16'h00C5);
    run(4'h8, 1'b0, 20'h00000, 16'h0000);
    check({13'h0000, mode_o}, 16'h0000);
    $display("test security done");
  endtask

  task automatic t_refuse;
    run(4'hC, 1'b0, 20'h00020, 16'h0000);
    check({15'h0000, ref_seen}, 16'h0001);
    supply_ok_i = 0;
    repeat (3) @(negedge sys_clk_i);
    run(4'h0, 1'b0, 20'h00020, 16'h0000);
    check({15'h0000, ref_seen}, 16'h0001);
    supply_ok_i = 1;
    repeat (3) @(negedge sys_clk_i);
    rd_chk(20'h00020, 16'hFFFF);
    $display("test refuse done");
  endtask

  task automatic t_reset;
    int i;
    run(4'h5, 1'b0, 20'h00000, 16'h0000);
    @(negedge sys_clk_i);
    fl_reset_req = 1;
    @(negedge sys_clk_i);
    fl_reset_req = 0;
    check({15'h0000, busy_o}, 16'h0001);
    wait_idle;
    check({13'h0000, mode_o}, 16'h0000);
    rd_chk(20'h00001, 16'hFFFF);
    // interrupt a program while it is polled, then reissue it
    @(negedge sys_clk_i);
    op_i = 4'h0;
    rd_i = 1'b0;
    addr_i = 20'h00300;
    wdata_i = 16'h00AA;
    req_i = 1;
    @(negedge sys_clk_i);
    req_i = 0;
    for (i = 0; i < 3000 && fl_oe_n_o !== 1'b0; i++) @(negedge sys_clk_i);
    if (i == 3000) begin
      n_errors++;
      give_verdict;
    end
    fl_reset_req = 1;
    @(negedge sys_clk_i);
    fl_reset_req = 0;
    wait_idle;
    check({15'h0000, reissue_o}, 16'h0001);
    run(4'h0, 1'b0, 20'h00300, 16'h00AA);
    check({15'h0000, reissue_o}, 16'h0000);
    rd_chk(20'h00300, 16'h00AA);
    $display("test reset done");
  endtask

  initial begin
    repeat (4) @(negedge sys_clk_i);
    reset_n_i = 1;
    wait_idle;
    t_ident;
    t_query;
    t_protect;
    t_sec;
    t_refuse;
    t_reset;
    give_verdict;
  end
endmodule
